// File: inc/tws_pkg.sv
// Shared constants and types for the two-wire memory slave front end.
// Assumes a 100 MHz system clock and a bus master that owns the serial clock.
package tws_pkg;

    // Array geometry
    localparam int          ADDR_W       = 12;
    localparam int          DATA_W       = 8;
    localparam int          MEM_DEPTH    = 4096;
    localparam int          PAGE_W       = 5;
    localparam logic [4:0]  PAGE_LAST    = 5'h1f;
    localparam logic [11:0] WPR_ADDR     = 12'hfff;

    // Bit counter marks within one byte slot
    localparam logic [3:0]  BIT_LAST     = 4'h7;
    localparam logic [3:0]  ACK_SLOT     = 4'h8;

    // Slave address field positions
    localparam int          SA_SEL_HI    = 7;
    localparam int          SA_SEL_LO    = 5;
    localparam int          SA_UPPER_HI  = 4;
    localparam int          SA_UPPER_LO  = 1;
    localparam int          SA_RW_BIT    = 0;

    // Protection register field positions and codes
    localparam int          WPR_WEL_BIT  = 1;
    localparam int          WPR_REG_WRITE_ENABLE_LATCH_BIT = 2;
    localparam int          WPR_BG_LO    = 3;
    localparam int          WPR_BG_HI    = 4;
    localparam int          WPR_ARM_BIT  = 7;
    localparam logic [7:0]  WPR_RESET    = 8'h00;
    localparam logic [6:0]  SET_WEL_CODE = 7'h01;
    localparam logic [6:0]  SET_REG_WRITE_ENABLE_LATCH_CODE = 7'h03;
    localparam logic [7:0]  CLEAR_CODE   = 8'h00;
    localparam logic [2:0]  PROG_LOW_CODE = 3'h2;
    localparam logic [1:0]  PROG_RSVD    = 2'h0;

    // Timing: self-timed programming cycle, and link reset pulse after stop
    localparam int          CLK_PERIOD_NS = 10;
    localparam int          T_WR_US       = 5000;
    localparam int unsigned WR_CYCLES     = (T_WR_US * 1000) / CLK_PERIOD_NS;
    localparam logic [1:0]  STOP_HOLD     = 2'h2;

    // Protection register layout
    typedef struct packed {
        logic       hw_protect_arm;
        logic [1:0] rsvd_hi;
        logic       block_guard_hi;
        logic       block_guard_lo;
        logic       reg_write_enable_latch;
        logic       write_enable_latch;
        logic       rsvd_lo;
    } tws_wpr_t;

    // Device select pins as a group
    typedef struct packed {
        logic a_n;
        logic b;
        logic c_n;
    } tws_sel_t;

    typedef enum logic [4:0] {
        L_IDLE  = 5'h01,
        L_ADDR  = 5'h02,
        L_WORD  = 5'h04,
        L_WDATA = 5'h08,
        L_RDATA = 5'h10
    } tws_link_st_t;

    typedef enum logic [2:0] {
        C_IDLE = 3'h1,
        C_PROG = 3'h2,
        C_WAIT = 3'h4
    } tws_commit_st_t;

endpackage

// File: rtl/tws_sync.sv
// Two-stage level synchroniser, one flop pair per bit.
// Assumes every bit is a level that stays put for several destination edges.
`timescale 1ns/100ps
`default_nettype none
module tws_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             arst_n,
    input  wire logic [WIDTH-1:0] d,
    output var  logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_q;

    // First stage feeds only the second
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end

endmodule
`default_nettype wire

// File: rtl/tws_eeprom_front.sv
// Slave front end of a 4096 x 8 two-wire serial memory with write protection.
// Assumes scl_clk is the master's serial clock, sda is open drain with pull-up.
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - Device is slave only; master starts transfers and drives the serial clock.
// - Data changes only while clock low; changes during clock high mean start/stop.
// - Watch lines always; start is data falling with clock high; idle until start.
// - Transactions end with stop: data rising while clock high.
// - Stop after a read sequence puts the device into standby.
// - Transmitter releases after eight bits; receiver pulls low in ninth clock.
// - After start, acknowledge once own slave address is recognised.
// - When selected for write, acknowledge each further received byte. Data bytes get no ack if the write-enable latch is clear, save a first register byte.
// - Read: shift eight bits, release, sample ack; on ack continue next byte.
// - No acknowledge from master during read ends further transmission.
// - Three device-select bits of the slave address match the select pins.
// - Two active-low select pins match inverted; the other matches directly.
// - Four slave-address bits form the upper array address with word address.
// - Last slave-address bit high means read, low means write.
// - Compare address after start; only on match acknowledge and run operation.
// - Protect pin low: hardware protection off, other protections still apply.
// - Protect pin high with arm bit set blocks guarded blocks and register writes.
// - Refuse nonvolatile writes until the write-enable latch is set.
// - Two guard bits protect none, top quarter, top half or whole array.
// - Highest address reaches the protection register instead of the array.
// - Accept page writes up to 32 bytes, then run timed programming cycle.
// - Writing 0000001x to the register address sets the write-enable latch.
// - Guard bits sit at register bit positions three and four.
// - Page write increments only the five low address bits, wrapping in page.
// - While programming runs, do not acknowledge the slave address.
module tws_eeprom_front #(
    parameter int unsigned WR_CYCLES = tws_pkg::WR_CYCLES
) (
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic scl_clk,
    input  wire logic sda_i,
    output var  logic sda_o,
    output var  logic sda_oe_n,
    input  wire logic select_pin_a_n,
    input  wire logic select_pin_b,
    input  wire logic select_pin_c_n,
    input  wire logic wp_pin,
    output var  logic standby,
    output var  logic write_busy
);

    // Array in the system domain; link side reads it only while it is idle
    logic [7:0]                  mem_q [0:tws_pkg::MEM_DEPTH-1];
    // Page staging buffer written on the link side
    logic [7:0]                  pg_data_q [0:(1 << tws_pkg::PAGE_W)-1];

    // System clock domain
    logic [4:0]                  sys_sync;
    logic                        scl_s;
    logic                        sda_s;
    logic                        wp_s;
    logic                        wr_req_s;
    logic                        rd_act_s;
    logic                        scl_prev_q;
    logic                        sda_prev_q;
    logic                        stop_evt;
    logic [1:0]                  lrst_cnt_q;
    logic                        link_rst_n_q;
    logic                        link_arst_n;
    tws_pkg::tws_commit_st_t     cst_q;
    logic [4:0]                  idx_q;
    logic [31:0]                 wait_q;
    tws_pkg::tws_wpr_t           wpr_q;
    tws_pkg::tws_wpr_t           wpr_d;
    logic                        hw_lock;
    logic [11:0]                 mem_wa;
    logic                        mem_we;

    // Link clock domain
    logic [11:0]                 link_sync;
    logic                        busy_l;
    tws_pkg::tws_wpr_t           wpr_l;
    tws_pkg::tws_sel_t           sel_l;
    tws_pkg::tws_link_st_t       lst_q;
    logic [3:0]                  cnt_q;
    logic [6:0]                  shift_q;
    logic                        ack_q;
    logic                        rw_q;
    logic [7:0]                  tx_q;
    logic                        sda_hi_q;
    logic                        start_tgl_q;
    logic                        start_ack_q;
    logic                        start_pend;
    logic [11:0]                 addr_q;
    logic [6:0]                  pg_base_q;
    logic [31:0]                 pg_valid_q;
    logic                        pg_hit_q;
    logic [7:0]                  pg_wpr_q;
    logic                        first_q;
    logic                        wr_req_q;
    logic                        rd_act_q;
    logic [7:0]                  rx_byte;
    logic                        at_wpr;
    logic                        ack_now;
    logic                        byte_done;
    logic                        rd_load;
    logic                        pg_we;

    // Select-bit compare; two pins are active low
    function automatic logic sel_match(input logic [7:0] sa, input tws_pkg::tws_sel_t sel);
        sel_match = (sa[tws_pkg::SA_SEL_HI:tws_pkg::SA_SEL_LO]
                     == {~sel.a_n, sel.b, ~sel.c_n});
    endfunction

    // Block guard decode over the array address
    function automatic logic guarded(input logic [11:0] a, input tws_pkg::tws_wpr_t w);
        unique case ({w.block_guard_hi, w.block_guard_lo})
            2'h0:    guarded = 1'b0;
            2'h1:    guarded = (a[11:10] == 2'h3);
            2'h2:    guarded = a[11];
            default: guarded = 1'b1;
        endcase
    endfunction

    // ---------------- System clock domain ----------------

    tws_sync #(.WIDTH(5)) u_sys_sync (
        .clk    (clk),
        .arst_n (arst_n),
        .d      ({scl_clk, sda_i, wp_pin, wr_req_q, rd_act_q}),
        .q      (sys_sync)
    );
    assign {scl_s, sda_s, wp_s, wr_req_s, rd_act_s} = sys_sync;

    // Line history for stop detection; starts at the synchroniser's reset level
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            scl_prev_q <= 1'b0;
            sda_prev_q <= 1'b0;
        end else begin
            scl_prev_q <= scl_s;
            sda_prev_q <= sda_s;
        end
    end

    assign stop_evt = scl_prev_q & scl_s & ~sda_prev_q & sda_s;

    // Stop ends the frame on the link side, which has no clock edge left
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            lrst_cnt_q   <= 2'h0;
            link_rst_n_q <= 1'b1;
        end else if (stop_evt) begin
            lrst_cnt_q   <= tws_pkg::STOP_HOLD;
            link_rst_n_q <= 1'b0;
        end else if (lrst_cnt_q != 2'h0) begin
            lrst_cnt_q   <= lrst_cnt_q - 2'h1;
        end else begin
            link_rst_n_q <= 1'b1;
        end
    end

    assign link_arst_n = arst_n & link_rst_n_q;

    // Standby after a stop that closes a read, left on bus activity
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            standby <= 1'b1;
        end else if (stop_evt && rd_act_s) begin
            standby <= 1'b1;
        end else if (scl_prev_q && !scl_s) begin
            standby <= 1'b0;
        end
    end

    // Programming sequencer: stage page into array, then self-timed wait
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cst_q      <= tws_pkg::C_IDLE;
            idx_q      <= 5'h0;
            wait_q     <= 32'h0;
            write_busy <= 1'b0;
        end else begin
            unique case (cst_q)
                tws_pkg::C_IDLE: begin
                    if (stop_evt && wr_req_s) begin
                        cst_q      <= tws_pkg::C_PROG;
                        idx_q      <= 5'h0;
                        write_busy <= 1'b1;
                    end
                end
                tws_pkg::C_PROG: begin
                    idx_q <= idx_q + 5'h1;
                    if (idx_q == tws_pkg::PAGE_LAST) begin
                        cst_q  <= tws_pkg::C_WAIT;
                        wait_q <= 32'h0;
                    end
                end
                tws_pkg::C_WAIT: begin
                    wait_q <= wait_q + 32'h1;
                    if (wait_q == WR_CYCLES - 32'h1) begin
                        cst_q      <= tws_pkg::C_IDLE;
                        write_busy <= 1'b0;
                    end
                end
            endcase
        end
    end

    assign hw_lock = wp_s & wpr_q.hw_protect_arm;

    // Protection register update from a staged register write
    always_comb begin
        wpr_d = wpr_q;
        if (cst_q == tws_pkg::C_PROG && idx_q == 5'h0 && pg_hit_q) begin
            if (wpr_q.reg_write_enable_latch
                && pg_wpr_q[tws_pkg::WPR_REG_WRITE_ENABLE_LATCH_BIT:0] == tws_pkg::PROG_LOW_CODE
                && pg_wpr_q[6:5] == tws_pkg::PROG_RSVD) begin
                if (!hw_lock) begin
                    wpr_d.hw_protect_arm = pg_wpr_q[tws_pkg::WPR_ARM_BIT];
                    wpr_d.block_guard_hi = pg_wpr_q[tws_pkg::WPR_BG_HI];
                    wpr_d.block_guard_lo = pg_wpr_q[tws_pkg::WPR_BG_LO];
                end
                wpr_d.reg_write_enable_latch = 1'b0;
            end else if (pg_wpr_q[7:1] == tws_pkg::SET_WEL_CODE) begin
                wpr_d.write_enable_latch = 1'b1;
            end else if (pg_wpr_q[7:1] == tws_pkg::SET_REG_WRITE_ENABLE_LATCH_CODE && wpr_q.write_enable_latch) begin
                wpr_d.reg_write_enable_latch = 1'b1;
            end else if (pg_wpr_q == tws_pkg::CLEAR_CODE) begin
                wpr_d.write_enable_latch     = 1'b0;
                wpr_d.reg_write_enable_latch = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wpr_q <= tws_pkg::WPR_RESET;
        end else begin
            wpr_q <= wpr_d;
        end
    end

    // Array write gating by latch and block guard
    assign mem_wa = {pg_base_q, idx_q};
    assign mem_we = (cst_q == tws_pkg::C_PROG) && pg_valid_q[idx_q]
                    && wpr_q.write_enable_latch
                    && !guarded(mem_wa, wpr_q);

    always_ff @(posedge clk) begin
        if (mem_we) begin
            mem_q[mem_wa] <= pg_data_q[idx_q];
        end
    end

    // ---------------- Link clock domain ----------------

    tws_sync #(.WIDTH(12)) u_link_sync (
        .clk    (scl_clk),
        .arst_n (arst_n),
        .d      ({write_busy, wpr_q, select_pin_a_n, select_pin_b, select_pin_c_n}),
        .q      (link_sync)
    );
    assign busy_l = link_sync[11];
    assign wpr_l  = link_sync[10:3];
    assign sel_l  = link_sync[2:0];

    assign start_pend = start_tgl_q ^ start_ack_q;
    assign rx_byte    = {shift_q, sda_i};
    assign at_wpr     = (addr_q == tws_pkg::WPR_ADDR);
    assign byte_done  = (cnt_q == tws_pkg::BIT_LAST) && !start_pend;

    // Acknowledge decision on the eighth received bit
    always_comb begin
        unique case (lst_q)
            tws_pkg::L_ADDR:  ack_now = sel_match(rx_byte, sel_l) && !busy_l;
            tws_pkg::L_WORD:  ack_now = 1'b1;
            tws_pkg::L_WDATA: ack_now = wpr_l.write_enable_latch || (first_q && at_wpr);
            default:          ack_now = 1'b0;
        endcase
    end

    assign rd_load = !start_pend && cnt_q == tws_pkg::ACK_SLOT
                     && ((lst_q == tws_pkg::L_ADDR && ack_q && rw_q)
                         || (lst_q == tws_pkg::L_RDATA && !sda_i));
    assign pg_we   = byte_done && lst_q == tws_pkg::L_WDATA && ack_now && !(first_q && at_wpr);

    // Start seen at falling clock: data went low during the high phase
    always_ff @(negedge scl_clk or negedge link_arst_n) begin
        if (!link_arst_n) begin
            start_tgl_q <= 1'b0;
            sda_oe_n    <= 1'b1;
            sda_o       <= 1'b0;
        end else if (sda_hi_q && !sda_i) begin
            start_tgl_q <= ~start_tgl_q;
            sda_oe_n    <= 1'b1;
        end else if (lst_q == tws_pkg::L_RDATA) begin
            sda_oe_n    <= (cnt_q == tws_pkg::ACK_SLOT) ? 1'b1 : tx_q[7];
        end else begin
            sda_oe_n    <= ~(ack_q && cnt_q == tws_pkg::ACK_SLOT);
        end
    end

    // Bit engine on rising clock; cleared by the stop-driven reset
    always_ff @(posedge scl_clk or negedge link_arst_n) begin
        if (!link_arst_n) begin
            lst_q       <= tws_pkg::L_IDLE;
            cnt_q       <= 4'h0;
            shift_q     <= 7'h0;
            ack_q       <= 1'b0;
            rw_q        <= 1'b0;
            tx_q        <= 8'hff;
            sda_hi_q    <= 1'b1;
            start_ack_q <= 1'b0;
        end else begin
            sda_hi_q <= sda_i;
            if (start_pend) begin
                start_ack_q <= start_tgl_q;
                lst_q       <= tws_pkg::L_ADDR;
                shift_q     <= {6'h0, sda_i};
                cnt_q       <= 4'h1;
                ack_q       <= 1'b0;
            end else if (rd_load) begin
                lst_q <= tws_pkg::L_RDATA;
                cnt_q <= 4'h0;
                ack_q <= 1'b0;
                tx_q  <= (lst_q == tws_pkg::L_ADDR && at_wpr) ? wpr_l : mem_q[addr_q];
            end else if (lst_q == tws_pkg::L_RDATA) begin
                if (cnt_q == tws_pkg::ACK_SLOT) begin
                    lst_q <= tws_pkg::L_IDLE;
                end else begin
                    tx_q  <= {tx_q[6:0], 1'b1};
                    cnt_q <= cnt_q + 4'h1;
                end
            end else if (lst_q != tws_pkg::L_IDLE) begin
                if (cnt_q < tws_pkg::BIT_LAST) begin
                    shift_q <= {shift_q[5:0], sda_i};
                    cnt_q   <= cnt_q + 4'h1;
                end else if (cnt_q == tws_pkg::BIT_LAST) begin
                    ack_q <= ack_now;
                    rw_q  <= (lst_q == tws_pkg::L_ADDR) ? sda_i : rw_q;
                    cnt_q <= tws_pkg::ACK_SLOT;
                end else begin
                    cnt_q <= 4'h0;
                    ack_q <= 1'b0;
                    if (!ack_q) begin
                        lst_q <= tws_pkg::L_IDLE;
                    end else if (lst_q == tws_pkg::L_ADDR) begin
                        lst_q <= tws_pkg::L_WORD;
                    end else begin
                        lst_q <= tws_pkg::L_WDATA;
                    end
                end
            end
        end
    end

    // Address counter and page staging survive across frames
    always_ff @(posedge scl_clk or negedge arst_n) begin
        if (!arst_n) begin
            addr_q     <= 12'h0;
            pg_base_q  <= 7'h0;
            pg_valid_q <= 32'h0;
            pg_hit_q   <= 1'b0;
            pg_wpr_q   <= 8'h0;
            first_q    <= 1'b0;
            wr_req_q   <= 1'b0;
            rd_act_q   <= 1'b0;
        end else if (start_pend) begin
            wr_req_q <= 1'b0;
            rd_act_q <= 1'b0;
        end else if (rd_load) begin
            addr_q   <= addr_q + 12'h1;
            rd_act_q <= 1'b1;
        end else if (byte_done && ack_now) begin
            unique case (lst_q)
                tws_pkg::L_ADDR: begin
                    if (!sda_i) begin
                        addr_q[11:8] <= rx_byte[tws_pkg::SA_UPPER_HI:tws_pkg::SA_UPPER_LO];
                    end
                end
                tws_pkg::L_WORD: begin
                    addr_q[7:0] <= rx_byte;
                    pg_base_q   <= {addr_q[11:8], rx_byte[7:5]};
                    pg_valid_q  <= 32'h0;
                    pg_hit_q    <= 1'b0;
                    first_q     <= 1'b1;
                end
                tws_pkg::L_WDATA: begin
                    if (first_q && at_wpr) begin
                        pg_hit_q <= 1'b1;
                        pg_wpr_q <= rx_byte;
                    end else begin
                        pg_valid_q[addr_q[4:0]] <= 1'b1;
                    end
                    addr_q[4:0] <= addr_q[4:0] + 5'h1;
                    first_q     <= 1'b0;
                    wr_req_q    <= 1'b1;
                end
                default: begin
                end
            endcase
        end
    end

    // Page byte staging
    always_ff @(posedge scl_clk) begin
        if (pg_we) begin
            pg_data_q[addr_q[4:0]] <= rx_byte;
        end
    end

endmodule
`default_nettype wire

// File: bench/tws_props.sv
// Port checker for the two-wire memory front end.
// Assumes it is bound onto tws_eeprom_front.
`timescale 1ns/100ps
`default_nettype none
module tws_props #(
    parameter int unsigned WR_CYCLES = 20
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic scl_clk,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_n,
    input wire logic select_pin_a_n,
    input wire logic select_pin_b,
    input wire logic select_pin_c_n,
    input wire logic wp_pin,
    input wire logic standby,
    input wire logic write_busy
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    int unsigned busy_q;
    // Cycles spent in the current programming cycle
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) busy_q <= '0;
        else busy_q <= write_busy ? busy_q + 1 : '0;
    end
    // Stop seen on the wire
    sequence s_stop;
        scl_clk && $rose(sda_i);
    endsequence
    // Recent serial clock fall before leaving standby
    property p_wake;
        $fell(standby) |-> !$past(scl_clk, 2) || !$past(scl_clk, 3) || !$past(scl_clk, 4);
    endproperty
    a_drive_low: assert property ($fell(sda_oe_n) |-> !scl_clk)
        else $error("drive began with clock high");
    a_stop_release: assert property (s_stop |-> ##[1:6] sda_oe_n)
        else $error("line held after stop");
    a_ack_bounded: assert property ($fell(sda_oe_n) |-> ##[1:34] $rose(sda_oe_n))
        else $error("line not released");
    a_busy_quiet: assert property (write_busy |-> sda_oe_n)
        else $error("answered while busy");
    a_busy_at_stop: assert property ($rose(write_busy) |-> scl_clk && sda_i)
        else $error("busy without stop");
    a_busy_max: assert property (busy_q <= WR_CYCLES + 40)
        else $error("busy too long");
    a_busy_min: assert property ($fell(write_busy) |-> $past(busy_q) >= WR_CYCLES)
        else $error("busy too short");
    a_standby_stop: assert property ($rose(standby) |-> scl_clk && sda_i)
        else $error("standby without stop");
    a_standby_wake: assert property (p_wake)
        else $error("woke without clock");
endmodule
bind tws_eeprom_front tws_props #(.WR_CYCLES(WR_CYCLES)) props_u (
    .clk(clk), .arst_n(arst_n), .scl_clk(scl_clk), .sda_i(sda_i), .sda_o(sda_o),
    .sda_oe_n(sda_oe_n), .select_pin_a_n(select_pin_a_n), .select_pin_b(select_pin_b),
    .select_pin_c_n(select_pin_c_n), .wp_pin(wp_pin), .standby(standby),
    .write_busy(write_busy)
);
`default_nettype wire

// File: bench/tws_bus_master.sv
// Bus master model: makes the serial clock, drives and samples data.
// Assumes a pulled-up wire; 32 ns bit; clock stands high between frames.
`timescale 1ns/100ps
`default_nettype none
module tws_bus_master (
    output var  logic scl,
    output var  logic sda,
    input  wire logic sda_w
);
    logic [7:0] obs;
    event       done;
    // Both lines released at rest
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    // One bit, data moved with clock low
    task automatic slot(input logic b, output logic r);
        sda = b;
        #8 scl = 1'b1;
        #8 r = sda_w;
        #8 scl = 1'b0;
        #8;
    endtask
    task automatic start;
        sda = 1'b1;
        #8 scl = 1'b1;
        #16 sda = 1'b0;
        #8 scl = 1'b0;
        #8;
    endtask
    task automatic stop;
        sda = 1'b0;
        #8 scl = 1'b1;
        #16 sda = 1'b1;
        #64;
    endtask
    task automatic send(input logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) slot(d[i], r);
        slot(1'b1, r);
        obs = {7'h00, ~r};
        -> done;
    endtask
    task automatic recv(input logic nack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            slot(1'b1, r);
            obs[i] = r;
        end
        slot(nack, r);
        -> done;
    endtask
endmodule
`default_nettype wire

// File: bench/tb_top.sv
// Self-checking bench for the memory front end.
// Assumes the bus master model and the bound port checker.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic       clk = 1'b0;
    logic       arst_n = 1'b1;
    logic [2:0] sel = 3'h0;
    logic       wp = 1'b0;
    logic       scl;
    logic       m_sda;
    logic       sda_o;
    logic       sda_oe_n;
    logic       standby;
    logic       write_busy;
    logic [7:0] dat;
    logic [2:0] sa;
    logic [7:0] exp_q[$];
    int         failures = 0;
    int         checks = 0;
    int         cycles = 0;
    wire logic  sda_w = m_sda & (sda_oe_n | sda_o);
    always #5 clk = ~clk;
    tws_eeprom_front #(.WR_CYCLES(40)) dut_u (
        .clk(clk), .arst_n(arst_n), .scl_clk(scl), .sda_i(sda_w), .sda_o(sda_o),
        .sda_oe_n(sda_oe_n), .select_pin_a_n(sel[2]), .select_pin_b(sel[1]),
        .select_pin_c_n(sel[0]), .wp_pin(wp), .standby(standby), .write_busy(write_busy)
    );
    tws_bus_master m_u (.scl(scl), .sda(m_sda), .sda_w(sda_w));
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        checks++;
        if (seen !== want) begin
            failures++;
            $display("[ERR] %0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic results;
        if (failures == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Sends a byte, noting the answer expected
    task automatic put(input logic [7:0] d, input logic [7:0] e);
        exp_q.push_back(e);
        m_u.send(d);
    endtask
    task automatic head(input logic [3:0] up, input logic [7:0] w);
        m_u.start();
        put({sa, up, 1'b0}, 8'h01);
        put(w, 8'h01);
    endtask
    task automatic wr(input logic [3:0] up, input logic [7:0] w, input logic [7:0] d);
        head(up, w);
        put(d, 8'h01);
        m_u.stop();
        check({7'h00, write_busy}, 8'h01);
        check({7'h00, standby}, 8'h00);
    endtask
    task automatic rd(input logic [3:0] up, input logic [7:0] w, input logic [7:0] e);
        head(up, w);
        m_u.start();
        put({sa, up, 1'b1}, 8'h01);
        exp_q.push_back(e);
        m_u.recv(1'b1);
        m_u.stop();
        repeat (8) @(posedge clk);
        check({7'h00, standby}, 8'h01);
    endtask
    // Waits out the programming cycle, bounded
    task automatic idle;
        for (int i = 0; i < 300 && write_busy !== 1'b0; i++) @(posedge clk);
        check({7'h00, write_busy}, 8'h00);
    endtask
    // Compares each bus result with the oldest note
    always @(m_u.done) check(m_u.obs, exp_q.pop_front());
    // Cuts a hang short
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            results();
        end
    end
    initial begin
        // Falling edge once every process waits, so async resets fire
        arst_n <= 1'b0;
        dat = lfsr(8'h23);
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        sel <= dat[2:0];
        wp <= dat[3];
        dat = lfsr(dat);
        repeat (4) @(posedge clk);
        sa = {~sel[2], sel[1], ~sel[0]};
        #3;
        // Wrong select bits draw no answer
        m_u.start();
        put({sa ^ 3'h1, 5'h00}, 8'h00);
        m_u.stop();
        wr(4'hf, 8'hff, 8'h02);
        // Poll while programming
        m_u.start();
        put({sa, 5'h00}, 8'h00);
        m_u.stop();
        idle();
        wr(4'h1, 8'h23, dat);
        idle();
        rd(4'h1, 8'h23, dat);
        rd(4'hf, 8'hff, 8'h02);
        results();
    end
endmodule
`default_nettype wire
